//--- shared/timer_regs.svh
// Purpose: Register map, field positions, reset values and divider counts
//          for the dual timer/counter block.
// Assumes: Registers are addressed by word index; byte address is 4x index.
// Notes:   Definitions only.
//
// Contract
// - Timer mode counts every twelve system clocks by default
// - Timer A divider bit one: divide by four
// - Timer A divider bit zero: divide by twelve
// - Timer B divides by four or twelve likewise
// - Counter mode counts falling edges of count pin
// - Timer B flag cleared by interrupt entry, software
// - Timer A flag cleared by interrupt entry, software
// - Timer B counts only while its run bit set or timer A split
// - Timer A counts only while its run bit set, except its split high half
// - Timer B gate bit makes its pin gate counting
// - Timer A gate bit makes its pin gate counting
// - Timer B source select picks pin or divided clock
// - Timer A source select picks pin or divided clock
// - Mode 00: 5-bit prescaler feeding 8-bit high byte
// - Mode 01: low and high byte form 16 bits
// - Mode 10: low byte reloads from high byte
// - Mode 11 splits timer A into two counters
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define IDX_RUN_FLAG      8'h88
`define IDX_MODE_SEL      8'h89
`define IDX_A_LOW         8'h8a
`define IDX_B_LOW         8'h8b
`define IDX_A_HIGH        8'h8c
`define IDX_B_HIGH        8'h8d
`define IDX_CLK_DIV       8'h8e

`define RST_RUN_FLAG      8'h00
`define RST_MODE_SEL      8'h00
`define RST_CLK_DIV       8'hc7
`define RST_COUNT         8'h00

`define BIT_B_FLAG        7
`define BIT_B_RUN         6
`define BIT_A_FLAG        5
`define BIT_A_RUN         4

`define BIT_B_GATE        7
`define BIT_B_SRC         6
`define BIT_B_MODE_HI     5
`define BIT_B_MODE_LO     4
`define BIT_A_GATE        3
`define BIT_A_SRC         2
`define BIT_A_MODE_HI     1
`define BIT_A_MODE_LO     0

`define BIT_B_DIV         4
`define BIT_A_DIV         3

`define DIV_SLOW          12
`define DIV_FAST          4

`endif

//--- shared/timer_pkg.sv
// Purpose: Types shared by the dual timer/counter block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Mode codes follow the two-bit mode field order.
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } timerMode_t;

  typedef logic [7:0] byte_t;

endpackage

//--- core/dual_legacy_timer_counter.sv
// Purpose: Two 16-bit timer/counters with run, gate, source and mode
//          control, reached over an Avalon-MM slave with waitrequest.
// Assumes: Single 125 MHz clock; pins are asynchronous and synchronised.
// Notes:   Every access takes one wait cycle; data in the low byte lane.
`timescale 1ns/1ps
`include "timer_regs.svh"

module dual_legacy_timer_counter
  import timer_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] avsAddress,
  input  wire logic              avsRead,
  input  wire logic              avsWrite,
  input  wire logic [31:0]       avsWriteData,
  input  wire logic [3:0]        avsByteEnable,
  output logic      [31:0]       avsReadData,
  output logic                   avsWaitRequest,
  input  wire logic              timerAInputPin,
  input  wire logic              timerBInputPin,
  input  wire logic              timerAGatePin,
  input  wire logic              timerBGatePin,
  input  wire logic              timerAIntAck,
  input  wire logic              timerBIntAck,
  output logic                   timerAOverflowFlag,
  output logic                   timerBOverflowFlag
);

  localparam logic [3:0] PRE_LAST = 4'(`DIV_SLOW - 1);
  localparam logic [1:0] FAST_LAST = 2'(`DIV_FAST - 1);

  logic        rstS1_r;
  logic        rstS2_r;
  logic        rstnSys;
  logic [3:0]  pinS1_r;
  logic [3:0]  pinS2_r;
  logic [1:0]  pinS3_r;
  logic [3:0]  preCnt_r;
  logic        tickSlow;
  logic        tickFast;
  logic        ack_r;
  logic [31:0] readData_r;
  logic        addrOk;
  logic        wrEn;
  logic [7:0]  wd;
  logic [7:0]  rdVal;
  logic        wrRunFlag;
  logic        wrMode;
  logic        wrALo;
  logic        wrAHi;
  logic        wrBLo;
  logic        wrBHi;
  logic        wrClk;
  logic        runA_r;
  logic        runB_r;
  logic        flagA_r;
  logic        flagB_r;
  byte_t       modeSel_r;
  byte_t       clkDiv_r;
  byte_t       aLo_r;
  byte_t       aHi_r;
  byte_t       bLo_r;
  byte_t       bHi_r;
  timerMode_t  modeA;
  timerMode_t  modeB;
  logic        splitA;
  logic        fallA;
  logic        fallB;
  logic        gateOkA;
  logic        gateOkB;
  logic        divTickA;
  logic        divTickB;
  logic        srcA;
  logic        srcB;
  logic        incA;
  logic        incAHi;
  logic        incB;
  logic [16:0] stepA;
  logic [16:0] stepB;
  logic [8:0]  stepAHi;
  logic        ovfA;
  logic        ovfAHi;
  logic        ovfB;

  // Reset is released through two flops so all logic leaves reset together.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstS1_r <= 1'b0;
      rstS2_r <= 1'b0;
    end else begin
      rstS1_r <= 1'b1;
      rstS2_r <= rstS1_r;
    end
  end
  assign rstnSys = rstS2_r;

  // Pin order is {gate B, gate A, count B, count A}; a third stage on the
  // count pins gives the falling-edge history without touching stage one.
  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      pinS1_r <= 4'h0;
      pinS2_r <= 4'h0;
      pinS3_r <= 2'h0;
    end else begin
      pinS1_r <= {timerBGatePin, timerAGatePin,
                  timerBInputPin, timerAInputPin};
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r[1:0];
    end
  end
  assign fallA = pinS3_r[0] & ~pinS2_r[0];
  assign fallB = pinS3_r[1] & ~pinS2_r[1];

  // One shared prescaler gives both the slow and the fast tick.
  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      preCnt_r <= 4'h0;
    end else if (preCnt_r == PRE_LAST) begin
      preCnt_r <= 4'h0;
    end else begin
      preCnt_r <= preCnt_r + 4'h1;
    end
  end
  assign tickSlow = (preCnt_r == PRE_LAST);
  assign tickFast = (preCnt_r[1:0] == FAST_LAST);

  // Bus slave: the first cycle of a request waits, the second answers.
  assign avsWaitRequest = (avsRead | avsWrite) & ~ack_r;
  assign avsReadData = readData_r;
  assign addrOk = (avsAddress[1:0] == 2'h0);
  assign wrEn = avsWrite & ack_r & addrOk & avsByteEnable[0];
  assign wd = avsWriteData[7:0];

  always_comb begin
    wrRunFlag = 1'b0;
    wrMode = 1'b0;
    wrALo = 1'b0;
    wrAHi = 1'b0;
    wrBLo = 1'b0;
    wrBHi = 1'b0;
    wrClk = 1'b0;
    rdVal = 8'h00;
    if (addrOk) begin
      unique case (avsAddress[ADDR_W-1:2])
        (ADDR_W-2)'(`IDX_RUN_FLAG): begin
          wrRunFlag = wrEn;
          rdVal = {flagB_r, runB_r, flagA_r, runA_r, 4'h0};
        end
        (ADDR_W-2)'(`IDX_MODE_SEL): begin
          wrMode = wrEn;
          rdVal = modeSel_r;
        end
        (ADDR_W-2)'(`IDX_A_LOW): begin
          wrALo = wrEn;
          rdVal = aLo_r;
        end
        (ADDR_W-2)'(`IDX_B_LOW): begin
          wrBLo = wrEn;
          rdVal = bLo_r;
        end
        (ADDR_W-2)'(`IDX_A_HIGH): begin
          wrAHi = wrEn;
          rdVal = aHi_r;
        end
        (ADDR_W-2)'(`IDX_B_HIGH): begin
          wrBHi = wrEn;
          rdVal = bHi_r;
        end
        (ADDR_W-2)'(`IDX_CLK_DIV): begin
          wrClk = wrEn;
          rdVal = clkDiv_r;
        end
        default: begin
          rdVal = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      ack_r <= 1'b0;
      readData_r <= 32'h0;
    end else begin
      ack_r <= (avsRead | avsWrite) & ~ack_r;
      if (avsRead && !ack_r) begin
        readData_r <= {24'h0, rdVal};
      end
    end
  end

  // Control registers.
  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      runA_r <= 1'(`RST_RUN_FLAG >> `BIT_A_RUN);
      runB_r <= 1'(`RST_RUN_FLAG >> `BIT_B_RUN);
    end else if (wrRunFlag) begin
      runA_r <= wd[`BIT_A_RUN];
      runB_r <= wd[`BIT_B_RUN];
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      modeSel_r <= `RST_MODE_SEL;
    end else if (wrMode) begin
      modeSel_r <= wd;
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      clkDiv_r <= `RST_CLK_DIV;
    end else if (wrClk) begin
      clkDiv_r <= wd;
    end
  end

  // Counting conditions.
  assign modeA = timerMode_t'({modeSel_r[`BIT_A_MODE_HI],
                               modeSel_r[`BIT_A_MODE_LO]});
  assign modeB = timerMode_t'({modeSel_r[`BIT_B_MODE_HI],
                               modeSel_r[`BIT_B_MODE_LO]});
  assign splitA = (modeA == MODE_SPLIT);
  assign gateOkA = ~modeSel_r[`BIT_A_GATE] | pinS2_r[2];
  assign gateOkB = ~modeSel_r[`BIT_B_GATE] | pinS2_r[3];
  assign divTickA = clkDiv_r[`BIT_A_DIV] ? tickFast : tickSlow;
  assign divTickB = clkDiv_r[`BIT_B_DIV] ? tickFast : tickSlow;
  assign srcA = modeSel_r[`BIT_A_SRC] ? fallA : divTickA;
  assign srcB = modeSel_r[`BIT_B_SRC] ? fallB : divTickB;
  assign incA = runA_r & gateOkA & srcA;
  // The split high half borrows timer B's run bit and flag.
  assign incAHi = splitA & runB_r & divTickA;
  // While A is split, B's run bit is taken, so B free-runs without a flag.
  assign incB = (splitA | runB_r) & gateOkB & srcB &
                (modeB != MODE_SPLIT);

  function automatic logic [16:0] stepCount(timerMode_t m, byte_t lo,
                                            byte_t hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    unique case (m)
      MODE_13BIT: begin
        r[4:0] = lo[4:0] + 5'h1;
        if (lo[4:0] == 5'h1f) begin
          r[15:8] = hi + 8'h1;
          r[16] = (hi == 8'hff);
        end
      end
      MODE_16BIT: begin
        r = {1'b0, hi, lo} + 17'h1;
      end
      MODE_RELOAD8: begin
        r[7:0] = lo + 8'h1;
        if (lo == 8'hff) begin
          r[7:0] = hi;
          r[16] = 1'b1;
        end
      end
      MODE_SPLIT: begin
        {r[16], r[7:0]} = {1'b0, lo} + 9'h1;
      end
    endcase
    return r;
  endfunction

  assign stepA = stepCount(modeA, aLo_r, aHi_r);
  assign stepB = stepCount(modeB, bLo_r, bHi_r);
  assign stepAHi = {1'b0, aHi_r} + 9'h1;
  assign ovfA = incA & stepA[16];
  assign ovfAHi = incAHi & stepAHi[8];
  assign ovfB = incB & stepB[16] & ~splitA;

  // Count bytes; a software write wins over a count in the same cycle.
  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      aLo_r <= `RST_COUNT;
    end else if (wrALo) begin
      aLo_r <= wd;
    end else if (incA) begin
      aLo_r <= stepA[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      aHi_r <= `RST_COUNT;
    end else if (wrAHi) begin
      aHi_r <= wd;
    end else if (incAHi) begin
      aHi_r <= stepAHi[7:0];
    end else if (incA && !splitA) begin
      aHi_r <= stepA[15:8];
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      bLo_r <= `RST_COUNT;
    end else if (wrBLo) begin
      bLo_r <= wd;
    end else if (incB) begin
      bLo_r <= stepB[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      bHi_r <= `RST_COUNT;
    end else if (wrBHi) begin
      bHi_r <= wd;
    end else if (incB) begin
      bHi_r <= stepB[15:8];
    end
  end

  // Flags: a hardware overflow wins over an acknowledge or a write of zero.
  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      flagA_r <= 1'b0;
    end else if (ovfA) begin
      flagA_r <= 1'b1;
    end else if (wrRunFlag) begin
      flagA_r <= wd[`BIT_A_FLAG];
    end else if (timerAIntAck) begin
      flagA_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstnSys) begin
    if (!rstnSys) begin
      flagB_r <= 1'b0;
    end else if (ovfB || ovfAHi) begin
      flagB_r <= 1'b1;
    end else if (wrRunFlag) begin
      flagB_r <= wd[`BIT_B_FLAG];
    end else if (timerBIntAck) begin
      flagB_r <= 1'b0;
    end
  end

  assign timerAOverflowFlag = flagA_r;
  assign timerBOverflowFlag = flagB_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstnSys);

  a_slow_tick_period: assert property (
    tickSlow |-> ##12 tickSlow)
    else $error("slow tick not every twelve clocks");

  a_fast_tick_period: assert property (
    tickFast |=> !tickFast [*3] ##1 tickFast)
    else $error("fast tick not every four clocks");

  a_run_a_halt: assert property (
    !runA_r && !wrALo && !wrAHi && !splitA |=> $stable(aLo_r)
      && $stable(aHi_r))
    else $error("timer A moved while stopped");

  a_run_b_halt: assert property (
    !runB_r && !splitA && !wrBLo && !wrBHi |=> $stable(bLo_r)
      && $stable(bHi_r))
    else $error("timer B moved while stopped");

  a_gate_a_block: assert property (
    modeSel_r[`BIT_A_GATE] && !pinS2_r[2] && !wrALo |=> $stable(aLo_r))
    else $error("timer A counted with gate closed");

  a_pin_edge_count: assert property (
    fallA && runA_r && gateOkA && modeSel_r[`BIT_A_SRC] &&
    modeA == MODE_16BIT && !wrALo |=> aLo_r == $past(aLo_r) + 8'h1)
    else $error("timer A missed a pin falling edge");

  a_reload_low: assert property (
    incA && modeA == MODE_RELOAD8 && aLo_r == 8'hff && !wrALo
    |=> aLo_r == $past(aHi_r) && flagA_r)
    else $error("timer A mode 2 reload wrong");

  a_ack_clear_a: assert property (
    timerAIntAck && !ovfA && !wrRunFlag |=> !flagA_r)
    else $error("timer A flag not cleared by entry");

  a_ack_clear_b: assert property (
    timerBIntAck && !ovfB && !ovfAHi && !wrRunFlag |=> !flagB_r)
    else $error("timer B flag not cleared by entry");

  sequence sBusReq;
    (avsRead || avsWrite) && !ack_r;
  endsequence

  a_bus_one_wait: assert property (
    sBusReq |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("bus answer not after one wait cycle");

endmodule // dual_legacy_timer_counter

//--- test/timer_pin_model.sv
// Purpose: Drives the count and gate pins of the timer block.
// Assumes: Pins change just after a rising clock edge.
// Notes:   Count pins idle high; gate pins start low.
`timescale 1ns/1ps
module timer_pin_model (
  input  wire logic sys_clk,
  output logic      timerAInputPin,
  output logic      timerBInputPin,
  output logic      timerAGatePin,
  output logic      timerBGatePin
);
  initial begin
    timerAInputPin = 1'b1;
    timerBInputPin = 1'b1;
    timerAGatePin  = 1'b0;
    timerBGatePin  = 1'b0;
  end

  // Each pulse is long enough on both levels to pass the synchroniser.
  task automatic pulse(input bit t, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if (t) timerBInputPin <= 1'b0; else timerAInputPin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      if (t) timerBInputPin <= 1'b1; else timerAInputPin <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask

  task automatic gate(input bit t, input bit v);
    @(posedge sys_clk);
    if (t) timerBGatePin <= v; else timerAGatePin <= v;
  endtask
endmodule // timer_pin_model

//--- test/dual_legacy_timer_counter_test.sv
// Purpose: Self-checking bench for the dual timer/counter block.
// Assumes: The bus master waits for waitrequest low; pin edges land in 3
//          clocks.
// Notes:   Count rates are judged within one count of the ideal value.
`timescale 1ns/1ps
`include "timer_regs.svh"
module dual_legacy_timer_counter_test;
  import timer_pkg::*;
  logic        sys_clk;
  logic        rstn;
  logic [9:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWriteData;
  logic [31:0] avsReadData;
  logic        avsWaitRequest;
  logic        timerAInputPin;
  logic        timerBInputPin;
  logic        timerAGatePin;
  logic        timerBGatePin;
  logic        timerAIntAck;
  logic        timerBIntAck;
  logic        timerAOverflowFlag;
  logic        timerBOverflowFlag;
  int          badCount;
  int          checksDone;

  dual_legacy_timer_counter i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'h1), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .timerAInputPin(timerAInputPin),
    .timerBInputPin(timerBInputPin), .timerAGatePin(timerAGatePin),
    .timerBGatePin(timerBGatePin), .timerAIntAck(timerAIntAck),
    .timerBIntAck(timerBIntAck), .timerAOverflowFlag(timerAOverflowFlag),
    .timerBOverflowFlag(timerBOverflowFlag)
  );

  timer_pin_model i_pins (
    .sys_clk(sys_clk), .timerAInputPin(timerAInputPin),
    .timerBInputPin(timerBInputPin), .timerAGatePin(timerAGatePin),
    .timerBGatePin(timerBGatePin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge that ends a cycle.
  task automatic access(input bit wr, input byte_t idx, input byte_t d,
                        output byte_t q);
    logic w;
    int   n;
    n = 0;
    avsAddress <= {idx, 2'b00};
    avsWriteData <= {24'h0, d};
    if (wr) avsWrite <= 1'b1; else avsRead <= 1'b1;
    do begin
      @(posedge sys_clk);
      w = avsWaitRequest;
      q = avsReadData[7:0];
      n++;
    end while (w !== 1'b0 && n < 20);
    if (w !== 1'b0) begin
      badCount++;
      endSim();
    end
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input byte_t i, input byte_t d);
    byte_t q;
    access(1'b1, i, d, q);
  endtask

  task automatic rdChk(input byte_t i, input byte_t e);
    byte_t q;
    access(1'b0, i, 8'h00, q);
    check({24'h0, q}, {24'h0, e});
  endtask

  function automatic logic flagOf(input bit t);
    return t ? timerBOverflowFlag : timerAOverflowFlag;
  endfunction

  task automatic resetRegs();
    rdChk(`IDX_RUN_FLAG, `RST_RUN_FLAG);
    rdChk(`IDX_MODE_SEL, `RST_MODE_SEL);
    rdChk(`IDX_CLK_DIV, `RST_CLK_DIV);
    rdChk(`IDX_A_LOW, `RST_COUNT);
    rdChk(8'h90, 8'h00);
    wr(8'h90, 8'h5a);
    wr(`IDX_B_HIGH, 8'ha5);
    rdChk(`IDX_B_HIGH, 8'ha5);
  endtask

  task automatic timerRate(input bit t, input bit fast);
    byte_t q;
    byte_t q2;
    int    k;
    k = fast ? 30 : 10;
    wr(`IDX_MODE_SEL, 8'h11);
    wr(`IDX_CLK_DIV, `RST_CLK_DIV | (8'(fast) << (t ? 4 : 3)));
    wr(8'h8a + t, 8'h00);
    wr(8'h8c + t, 8'h00);
    wr(`IDX_RUN_FLAG, t ? 8'h40 : 8'h10);
    repeat (120) @(posedge sys_clk);
    wr(`IDX_RUN_FLAG, 8'h00);
    access(1'b0, 8'h8a + t, 8'h00, q);
    check(32'(q >= k && q <= k + 1), 32'h1);
    repeat (40) @(posedge sys_clk);
    access(1'b0, 8'h8a + t, 8'h00, q2);
    check({24'h0, q2}, {24'h0, q});
  endtask

  task automatic pinCase(input bit t, input byte_t mode, input byte_t lo,
                         input byte_t hi, input byte_t eLo, input byte_t eHi,
                         input bit eFlag);
    byte_t run;
    run = t ? 8'h40 : 8'h10;
    wr(`IDX_MODE_SEL, mode);
    wr(8'h8a + t, lo);
    wr(8'h8c + t, hi);
    wr(`IDX_RUN_FLAG, run);
    i_pins.pulse(t, 1);
    rdChk(8'h8a + t, eLo);
    rdChk(8'h8c + t, eHi);
    check(32'(flagOf(t)), 32'(eFlag));
    rdChk(`IDX_RUN_FLAG, run | (eFlag ? (run << 1) : 8'h00));
  endtask

  task automatic flagClear(input bit t, input bit byAck);
    if (byAck) begin
      if (t) timerBIntAck <= 1'b1; else timerAIntAck <= 1'b1;
      @(posedge sys_clk);
      timerAIntAck <= 1'b0;
      timerBIntAck <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end else begin
      wr(`IDX_RUN_FLAG, 8'h00);
    end
    check(32'(flagOf(t)), 32'h0);
  endtask

  task automatic gateCase(input bit t);
    wr(`IDX_MODE_SEL, t ? 8'hd0 : 8'h0d);
    wr(8'h8a + t, 8'h10);
    wr(`IDX_RUN_FLAG, t ? 8'h40 : 8'h10);
    i_pins.pulse(t, 2);
    rdChk(8'h8a + t, 8'h10);
    i_pins.gate(t, 1'b1);
    i_pins.pulse(t, 2);
    rdChk(8'h8a + t, 8'h12);
    i_pins.gate(t, 1'b0);
  endtask

  // Timer A split under timer B's run bit: A's high half counts, A's low half holds; then timer B in mode 11 holds.
  task automatic splitCase();
    wr(`IDX_MODE_SEL, 8'h03);
    wr(`IDX_CLK_DIV, `RST_CLK_DIV | 8'h08);
    wr(`IDX_A_LOW, 8'h40);
    wr(`IDX_A_HIGH, 8'hfe);
    wr(`IDX_RUN_FLAG, 8'h40);
    repeat (12) @(posedge sys_clk);
    rdChk(`IDX_RUN_FLAG, 8'hc0);
    rdChk(`IDX_A_LOW, 8'h40);
    check(32'(timerBOverflowFlag), 32'h1);
    flagClear(1'b1, 1'b0);
    wr(`IDX_MODE_SEL, 8'h30);
    wr(`IDX_B_LOW, 8'h21);
    wr(`IDX_RUN_FLAG, 8'h40);
    repeat (30) @(posedge sys_clk);
    rdChk(`IDX_B_LOW, 8'h21);
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    badCount++;
    endSim();
  end

  initial begin
    rstn = 1'b0;
    avsAddress = 10'h000;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0;
    timerAIntAck = 1'b0;
    timerBIntAck = 1'b0;
    badCount = 0;
    checksDone = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    resetRegs();
    for (int i = 0; i < 4; i++) timerRate(i[0], i[1]);
    pinCase(0, 8'h04, 8'hff, 8'hff, 8'he0, 8'h00, 1'b1);
    flagClear(1'b0, 1'b1);
    pinCase(0, 8'h05, 8'hff, 8'h12, 8'h00, 8'h13, 1'b0);
    pinCase(0, 8'h06, 8'hfe, 8'h33, 8'hff, 8'h33, 1'b0);
    pinCase(0, 8'h06, 8'hff, 8'h33, 8'h33, 8'h33, 1'b1);
    flagClear(1'b0, 1'b0);
    pinCase(1, 8'h60, 8'hff, 8'h80, 8'h80, 8'h80, 1'b1);
    flagClear(1'b1, 1'b0);
    pinCase(1, 8'h40, 8'h1f, 8'h01, 8'h00, 8'h02, 1'b0);
    pinCase(1, 8'h50, 8'hff, 8'hff, 8'h00, 8'h00, 1'b1);
    flagClear(1'b1, 1'b1);
    gateCase(1'b0);
    gateCase(1'b1);
    splitCase();
    endSim();
  end
endmodule // dual_legacy_timer_counter_test
